// >>> hw/poie_top.sv
// APB register bank for the performance-monitor overflow interrupt enables.
//
// Summary of operation
// - Writing the set view with bit 31 high enables the cycle-counter overflow interrupt.
// - Writing the set view with any of bits 0 to 3 high enables that event counter's interrupt.
// - Writing the clear view with bit 31 high disables the cycle-counter overflow interrupt.
// - Writing the clear view with any of bits 0 to 3 high disables that event counter's interrupt.
// - Both views act on one shared set of enable flops.
// - Reading either view returns the same current enable status.
// - A zero written to any enable bit in either view leaves it unchanged.
// - After reset all five enables are zero.
// - A counter's overflow raises an interrupt request only while its enable is set.
// - Overflow flags are set by counter overflow or the flag set view and cleared by writing one to the flag clear view.
`timescale 1ns/1ns
module poie_top
#(
    parameter int unsigned NUM_EVENT = poie_pkg::NUM_EVENT,
    parameter int unsigned CYCLE_BIT = poie_pkg::CYCLE_BIT
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [3:0]  event_overflow,
    input  wire logic        cycle_overflow,
    output logic             overflow_irq
);
    logic [4:0]  enable_reg;
    logic [4:0]  ovf_reg;
    logic [4:0]  overflow_event;
    logic [4:0]  wmask;
    logic [31:0] rdata_next;
    logic        hit;
    logic        access;
    logic        ovf_view;
    logic [4:0]  pend;
    poie_pkg::poie_op_t op_next;

    poie_wr_if wr_bus ();

    // Slave answers in the first access cycle: no wait states.
    // Every register is a plain flop, so there is nothing to wait for, and a
    // master that holds its request longer gains nothing but lost bus time.
    assign pready = 1'b1;
    assign access = psel & penable;
    assign overflow_event = {cycle_overflow, event_overflow};

    // Per event counter, a one in lane zero reaches the mask only when that lane is strobed.
    for (genvar gi = 0; gi < NUM_EVENT; gi++)
    begin : g_event_mask
        assign wmask[gi] = pwdata[gi] & pstrb[poie_pkg::LANE_EVENT];
    end

    // The cycle enable rides in the top lane; bits 30 to 4 never reach the flag store.
    assign wmask[poie_pkg::CYCLE_IDX] =
        pwdata[CYCLE_BIT] & pstrb[poie_pkg::LANE_CYCLE];

    // Any other layout would misplace fields in the read word, so it is refused.
    if (NUM_EVENT != poie_pkg::NUM_EVENT || CYCLE_BIT != poie_pkg::CYCLE_BIT)
    begin : g_bad_layout
        $error("poie_top serves only four event counters with the cycle bit on top");
    end

    // Address decode and write classification.
    always_comb
    begin
        hit      = 1'b1;
        ovf_view = 1'b0;
        op_next  = poie_pkg::POIE_OP_NONE;
        if (paddr == poie_pkg::OFS_ENABLE_SET)
            op_next = poie_pkg::POIE_OP_EN_SET;
        else if (paddr == poie_pkg::OFS_ENABLE_CLEAR)
            op_next = poie_pkg::POIE_OP_EN_CLR;
        else if (paddr == poie_pkg::OFS_OVF_SET)
        begin
            op_next  = poie_pkg::POIE_OP_OV_SET;
            ovf_view = 1'b1;
        end
        else if (paddr == poie_pkg::OFS_OVF_CLEAR)
        begin
            op_next  = poie_pkg::POIE_OP_OV_CLR;
            ovf_view = 1'b1;
        end
        else
            hit = 1'b0;
        if (!(access && pwrite))
            op_next = poie_pkg::POIE_OP_NONE;
    end

    assign wr_bus.op   = op_next;
    assign wr_bus.mask = wmask;

    poie_flags u_flags
    (
        .pclk           (pclk),
        .presetn        (presetn),
        .wr             (wr_bus),
        .overflow_event (overflow_event),
        .enable_reg     (enable_reg),
        .ovf_reg        (ovf_reg)
    );

    // Read mux: both enable views return the same word, reserved bits zero.
    always_comb
    begin
        rdata_next = poie_pkg::ZERO_WORD;
        if (ovf_view)
        begin
            rdata_next[poie_pkg::CYCLE_BIT] = ovf_reg[poie_pkg::CYCLE_IDX];
            rdata_next[3:0]                 = ovf_reg[3:0];
        end
        else if (hit)
        begin
            rdata_next[poie_pkg::CYCLE_BIT] = enable_reg[poie_pkg::CYCLE_IDX];
            rdata_next[3:0]                 = enable_reg[3:0];
        end
    end

    // Read data registered at the setup cycle so it stands through the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= poie_pkg::ZERO_WORD;
        else if (psel && !penable && !pwrite)
            prdata <= rdata_next;
    end

    // Unmapped addresses answer with an error; the error is registered with the read data.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else if (psel && !penable)
            pslverr <= ~hit;
    end

    // Interrupt gate: a flag counts only while its enable is set.
    assign pend = ovf_reg & enable_reg;
    assign overflow_irq = |pend;

    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        overflow_irq == |(ovf_reg & enable_reg)) else $error("irq not gated by enables");

    a_set_takes: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == poie_pkg::OFS_ENABLE_SET && pwdata[31] && pstrb[3])
        |=> enable_reg[4]) else $error("cycle enable not set");

    a_set_event: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == poie_pkg::OFS_ENABLE_SET && pstrb[0])
        |=> ((enable_reg[3:0] & $past(pwdata[3:0])) == $past(pwdata[3:0])))
        else $error("event enable not set");

    a_clr_takes: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == poie_pkg::OFS_ENABLE_CLEAR && pwdata[31] && pstrb[3])
        |=> !enable_reg[4]) else $error("cycle enable not cleared");

    a_clr_event: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == poie_pkg::OFS_ENABLE_CLEAR && pstrb[0])
        |=> ((enable_reg[3:0] & $past(pwdata[3:0])) == 4'h0))
        else $error("event enable not cleared");

    a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && (paddr == poie_pkg::OFS_ENABLE_SET
            || paddr == poie_pkg::OFS_ENABLE_CLEAR) && pwdata[31] == 1'b0 && pwdata[3:0] == 4'h0)
        |=> $stable(enable_reg)) else $error("zero write changed enables");

    a_views_equal: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && (paddr == poie_pkg::OFS_ENABLE_SET
            || paddr == poie_pkg::OFS_ENABLE_CLEAR))
        |=> prdata == {$past(enable_reg[4]), 27'h0, $past(enable_reg[3:0])})
        else $error("enable view read mismatch");

    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[30:4] == 27'h0) else $error("reserved bits not zero");

    a_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_overflow |=> ovf_reg[4]) else $error("overflow event lost");

    // Checks below run on the bus clock with reset as the guard, except the two reset checks.
    // Each write sequence marks the access edge of one decoded view,
    // so the consequent is judged one edge later, when the flops
    // have taken the new value. Shared sequences keep the checks
    // short and make sure every check sees the same decode.
    sequence s_en_set_wr;
        access && pwrite && paddr == poie_pkg::OFS_ENABLE_SET;
    endsequence

    sequence s_en_clr_wr;
        access && pwrite && paddr == poie_pkg::OFS_ENABLE_CLEAR;
    endsequence

    sequence s_ov_set_wr;
        access && pwrite && paddr == poie_pkg::OFS_OVF_SET;
    endsequence

    sequence s_ov_clr_wr;
        access && pwrite && paddr == poie_pkg::OFS_OVF_CLEAR;
    endsequence

    // Any cycle that writes neither enable view, idle cycles included.
    sequence s_no_en_wr;
        !(access && pwrite && (paddr == poie_pkg::OFS_ENABLE_SET
            || paddr == poie_pkg::OFS_ENABLE_CLEAR));
    endsequence

    // The setup cycle of a read, at whose edge the data register loads.
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence

    // Leaving reset every enable is clear; the reset guard is left out on purpose.
    a_reset_clear: assert property (@(posedge pclk)
        $rose(presetn) |-> enable_reg == poie_pkg::ENABLE_RESET)
        else $error("enables not clear after reset");

    // Leaving reset no flag is set and the interrupt is low.
    a_reset_quiet: assert property (@(posedge pclk)
        $rose(presetn) |-> (ovf_reg == poie_pkg::OVF_RESET && !overflow_irq))
        else $error("flags or interrupt active after reset");

    // A set write can only add enables, never drop one.
    a_set_only_adds: assert property (@(posedge pclk) disable iff (!presetn)
        s_en_set_wr |=> ($past(enable_reg) & ~enable_reg) == '0)
        else $error("set write dropped an enable");

    // A clear write can only drop enables, never add one.
    a_clr_only_drops: assert property (@(posedge pclk) disable iff (!presetn)
        s_en_clr_wr |=> (enable_reg & ~$past(enable_reg)) == '0)
        else $error("clear write added an enable");

    // Reads, idle cycles and flag writes leave the shared enables alone.
    a_others_keep: assert property (@(posedge pclk) disable iff (!presetn)
        s_no_en_wr |=> $stable(enable_reg))
        else $error("enables changed without an enable write");

    // With no lane strobed a set write is dropped as a whole.
    a_lane_off: assert property (@(posedge pclk) disable iff (!presetn)
        (s_en_set_wr ##0 pstrb == 4'h0) |=> $stable(enable_reg))
        else $error("unstrobed write changed enables");

    // With both lanes strobed the new enables are the old ones plus the written ones.
    a_set_exact: assert property (@(posedge pclk) disable iff (!presetn)
        (s_en_set_wr ##0 pstrb == 4'hF)
        |=> enable_reg == ($past(enable_reg) | {$past(pwdata[31]), $past(pwdata[3:0])}))
        else $error("set write result wrong");

    // With both lanes strobed the new enables are the old ones minus the written ones.
    a_clr_exact: assert property (@(posedge pclk) disable iff (!presetn)
        (s_en_clr_wr ##0 pstrb == 4'hF)
        |=> enable_reg == ($past(enable_reg) & ~{$past(pwdata[31]), $past(pwdata[3:0])}))
        else $error("clear write result wrong");

    // No enable at all means no interrupt, whatever the flags say.
    a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        enable_reg == '0 |-> !overflow_irq)
        else $error("interrupt with all enables clear");

    // No flag at all means no interrupt, whatever the enables say.
    a_irq_no_flags: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_reg == '0 |-> !overflow_irq)
        else $error("interrupt with no flag set");

    // Any enabled flag raises the interrupt at once.
    a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf_reg & enable_reg) != '0 |-> overflow_irq)
        else $error("enabled flag did not raise the interrupt");

    // The flag set view adds the written event flags.
    a_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ov_set_wr ##0 pstrb[0])
        |=> (ovf_reg[3:0] & $past(pwdata[3:0])) == $past(pwdata[3:0]))
        else $error("flag set write lost");

    // The flag clear view drops the written event flags when no overflow competes.
    a_ovf_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ov_clr_wr ##0 (pstrb[0] && event_overflow == 4'h0))
        |=> (ovf_reg[3:0] & $past(pwdata[3:0])) == 4'h0)
        else $error("flag clear write lost");

    // An event counter overflow always leaves its flag set.
    a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        event_overflow != 4'h0 |=> (ovf_reg[3:0] & $past(event_overflow)) == $past(event_overflow))
        else $error("event overflow lost");

    // Both flag views read the current flags in the enable layout.
    a_ovf_read: assert property (@(posedge pclk) disable iff (!presetn)
        (s_rd_setup ##0 (paddr == poie_pkg::OFS_OVF_SET || paddr == poie_pkg::OFS_OVF_CLEAR))
        |=> prdata == {$past(ovf_reg[4]), 27'h0, $past(ovf_reg[3:0])})
        else $error("flag view read mismatch");

    // An unmapped read returns an all-zero word.
    a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
        (s_rd_setup ##0 !hit) |=> prdata == poie_pkg::ZERO_WORD)
        else $error("unmapped read not zero");

    // An unmapped address is answered with an error.
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // Bus answer.
        (psel && !penable && !hit) |=> pslverr)
        else $error("unmapped access without error");

    // A mapped address is answered without an error.
    a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn) // Bus answer.
        (psel && !penable && hit) |=> !pslverr)
        else $error("mapped access with error");

    // The slave never inserts wait states.
    a_ready_high: assert property (@(posedge pclk) disable iff (!presetn) // Bus answer.
        pready == 1'b1)
        else $error("wait state inserted");

    // Read data stands until the next read setup.
    a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed while standing");

    // Per counter: a lone flag stays silent while disabled and speaks once enabled.
    for (genvar gc = 0; gc < poie_pkg::NUM_CTR; gc++)
    begin : g_ctr_check
        a_gate_bit: assert property (@(posedge pclk) disable iff (!presetn)
            (ovf_reg == (5'h01 << gc) && !enable_reg[gc]) |-> !overflow_irq)
            else $error("disabled counter raised the interrupt");
        a_pass_bit: assert property (@(posedge pclk) disable iff (!presetn)
            (ovf_reg[gc] && enable_reg[gc]) |-> overflow_irq)
            else $error("enabled counter did not raise the interrupt");
        a_set_bit: assert property (@(posedge pclk) disable iff (!presetn)
            (s_en_set_wr ##0 wmask[gc]) |=> enable_reg[gc])
            else $error("enable bit not set");
        a_clr_bit: assert property (@(posedge pclk) disable iff (!presetn)
            (s_en_clr_wr ##0 wmask[gc]) |=> !enable_reg[gc])
            else $error("enable bit not cleared");
    end
endmodule

// >>> hw/poie_pkg.sv
// Package with register map, field layout and reset values of the overflow interrupt-enable block.
package poie_pkg;
    localparam int unsigned ADDR_W           = 12;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned NUM_EVENT        = 4;
    localparam int unsigned NUM_CTR          = 5;
    localparam logic [11:0] OFS_ENABLE_SET   = 12'h000;
    localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h004;
    localparam logic [11:0] OFS_OVF_SET      = 12'h008;
    localparam logic [11:0] OFS_OVF_CLEAR    = 12'h00C;
    localparam int unsigned CYCLE_BIT        = 31;
    localparam int unsigned CYCLE_IDX        = 4;
    localparam int unsigned LANE_EVENT       = 0;
    localparam int unsigned LANE_CYCLE       = 3;
    localparam logic [4:0]  ENABLE_RESET     = 5'h00;
    localparam logic [4:0]  OVF_RESET        = 5'h00;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

    // Kind of register write decoded from the bus.
    typedef enum logic [2:0]
    {
        POIE_OP_NONE   = 3'b000,
        POIE_OP_EN_SET = 3'b001,
        POIE_OP_EN_CLR = 3'b010,
        POIE_OP_OV_SET = 3'b011,
        POIE_OP_OV_CLR = 3'b100
    } poie_op_t;
endpackage

// >>> hw/poie_wr_if.sv
// Interface carrying decoded register writes from the bus slave to the flag store.
`timescale 1ns/1ns
interface poie_wr_if;
    poie_pkg::poie_op_t op;
    logic [4:0]         mask;

    modport src (output op, output mask);
    modport dst (input op, input mask);
endinterface

// >>> hw/poie_flags.sv
// Shared enable and overflow flag storage with set and clear views.
`timescale 1ns/1ns
module poie_flags
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    poie_wr_if.dst      wr,
    input  wire logic [4:0] overflow_event,
    output logic [4:0]  enable_reg,
    output logic [4:0]  ovf_reg
);
    // One set of enable flops serves both views, so the views can never disagree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable_reg <= poie_pkg::ENABLE_RESET;
        else if (wr.op == poie_pkg::POIE_OP_EN_SET)
            enable_reg <= enable_reg | wr.mask;
        else if (wr.op == poie_pkg::POIE_OP_EN_CLR)
            enable_reg <= enable_reg & ~wr.mask;
    end

    // Hardware overflow beats a software clear in the same cycle so no event is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_reg <= poie_pkg::OVF_RESET;
        else if (wr.op == poie_pkg::POIE_OP_OV_CLR)
            ovf_reg <= (ovf_reg & ~wr.mask) | overflow_event;
        else if (wr.op == poie_pkg::POIE_OP_OV_SET)
            ovf_reg <= ovf_reg | wr.mask | overflow_event;
        else
            ovf_reg <= ovf_reg | overflow_event;
    end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the overflow interrupt-enable register bank.
`timescale 1ns/1ns
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [3:0]  event_overflow;
    logic        cycle_overflow;
    logic        overflow_irq;
    logic [4:0]  en_m;
    logic [4:0]  ov_m;
    logic [31:0] rd;
    logic        serr;
    int          err_count;
    int          compares;
    logic [11:0] addr_tab [5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};

    poie_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .event_overflow(event_overflow),
        .cycle_overflow(cycle_overflow), .overflow_irq(overflow_irq));

    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Case equality, so an unknown never passes for a match.
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Places the five enables or flags at their word positions.
    function automatic logic [31:0] xp(input logic [4:0] m);
        return {m[4], 27'h0, m[3:0]};
    endfunction

    // One APB transfer; the request is held until pready is seen high at an edge, or for at most 50 more edges.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // The interrupt level is only judged once the edge's updates have landed.
    task automatic settle();
        #1 chk("irq", {31'h0, overflow_irq}, {31'h0, |(en_m & ov_m)});
        @(posedge pclk);
    endtask

    task automatic wr_op(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [4:0] m;
        m = {d[31] & s[3], d[3:0] & {4{s[0]}}};
        apb(1'b1, a, d, s);
        case (a)
            12'h000: en_m = en_m | m;
            12'h004: en_m = en_m & ~m;
            12'h008: ov_m = ov_m | m;
            12'h00C: ov_m = ov_m & ~m;
            default: ;
        endcase
        chk("pslverr", {31'h0, serr}, {31'h0, a > 12'h00C});
        settle();
    endtask

    task automatic rd_op(input logic [11:0] a);
        logic [31:0] e;
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        e = (a == 12'h000 || a == 12'h004) ? xp(en_m) : (a <= 12'h00C) ? xp(ov_m) : 32'h0;
        chk("prdata", rd, e);
        chk("pslverr", {31'h0, serr}, {31'h0, a > 12'h00C});
        settle();
    endtask

    task automatic pulse(input logic [4:0] m);
        event_overflow <= m[3:0];
        cycle_overflow <= m[4];
        @(posedge pclk);
        event_overflow <= 4'h0;
        cycle_overflow <= 1'b0;
        ov_m = ov_m | m;
        settle();
    endtask

    task automatic wrap_up();
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog well beyond the eleven hundred or so cycles the sequence needs.
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        wrap_up();
    end

    initial
    begin
        logic [11:0] a;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {event_overflow, cycle_overflow} = '0;
        {en_m, ov_m, err_count, compares} = '0;
        presetn = 1'b0;
        void'($urandom(20));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_op(12'h000);
        rd_op(12'h004);
        pulse(5'h1F);
        wr_op(12'h000, 32'hFFFF_FFFF, 4'hF);
        rd_op(12'h004);
        // Drop one enable at a time, so each clear bit is seen on its own.
        for (int i = 0; i < 5; i++)
        begin
            wr_op(12'h004, (i == 4) ? 32'h8000_0000 : (32'h1 << i), 4'hF);
            rd_op(12'h000);
        end
        for (int i = 0; i < 400; i++)
        begin
            a = addr_tab[$urandom % 5];
            case ($urandom % 3)
                0: wr_op(a, $urandom, ($urandom % 4 == 0) ? 4'($urandom) : 4'hF);
                1: rd_op(a);
                default: pulse(5'($urandom));
            endcase
        end
        wrap_up();
    end
endmodule
